// ### src/dsf_pkg.sv
// Shared constants and carriers of the dual FIFO block
package dsf_pkg;
  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int DSF_DATA_W = 9;
  localparam int DSF_DEPTH = 256;
  localparam int DSF_NUM_FIFO = 2;
  localparam int DSF_NUM_EV = 4;
  localparam int DSF_REG_AW = 4;
  localparam int DSF_REG_DW = 16;
  localparam int DSF_SYNC_W = 8 + DSF_DATA_W;
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam int DSF_OFS_RST = 7;
  localparam logic [7:0] DSF_IRQ_EN_RST = 8'h00;
  // ------------------------------------------------------------
  // Register indices
  // ------------------------------------------------------------
  localparam logic [3:0] DSF_REG_STATUS = 4'h0;
  localparam logic [3:0] DSF_REG_IRQ_EN = 4'h1;
  localparam logic [3:0] DSF_REG_IRQ_CLR = 4'h2;
  localparam logic [3:0] DSF_REG_AE_OFS0 = 4'h3;
  localparam logic [3:0] DSF_REG_AF_OFS0 = 4'h4;
  localparam logic [3:0] DSF_REG_LEVEL0 = 4'h7;
  localparam logic [3:0] DSF_REG_MODE = 4'h9;
  localparam int DSF_OFS_STRIDE = 2;
  // ------------------------------------------------------------
  // Event bit positions, per FIFO group of four
  // ------------------------------------------------------------
  localparam int DSF_EV_EMPTY = 0;
  localparam int DSF_EV_FULL = 1;
  localparam int DSF_EV_RD_BLK = 2;
  localparam int DSF_EV_WR_BLK = 3;
  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic write_clock;
    logic write_enable_one_n;
    logic write_enable_two_or_offset_load;
    logic read_enable_one_n;
    logic read_enable_two_n;
    logic output_enable_n;
    logic resetN;
  } dsf_pins_t;
  typedef struct packed {
    logic empty_flag_n;
    logic almost_empty_flag_n;
    logic almost_full_flag_n;
    logic full_flag_n;
  } dsf_flags_t;
  typedef struct packed {
    logic wrEdge;
    logic rdEdge;
    logic wen1N;
    logic wen2;
    logic ren1N;
    logic ren2N;
    logic oeN;
    logic resetN;
    logic [DSF_DATA_W-1:0] data;
  } dsf_sync_t;
endpackage

// ### src/dsf_pin_sync.sv
// Pin synchroniser and clock-edge detector for one FIFO
`timescale 1ns/100ps
`default_nettype none
module dsf_pin_sync (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Pins
  input wire dsf_pkg::dsf_pins_t pins,
  input wire logic readClock,
  input wire logic [dsf_pkg::DSF_DATA_W-1:0] dataIn,
  // Synchronised view
  output dsf_pkg::dsf_sync_t syncOut
);
  import dsf_pkg::*;
  // ------------------------------------------------------------
  // Two-stage capture, plus history for the clocks
  // ------------------------------------------------------------
  logic [DSF_SYNC_W-1:0] raw;
  logic [DSF_SYNC_W-1:0] stage1_q;
  logic [DSF_SYNC_W-1:0] stage2_q;
  logic [1:0] clkPrev_q;
  assign raw = {pins.write_clock, readClock, pins.write_enable_one_n,
                pins.write_enable_two_or_offset_load, pins.read_enable_one_n,
                pins.read_enable_two_n, pins.output_enable_n, pins.resetN, dataIn};
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_q <= '0;
      stage2_q <= '0;
      clkPrev_q <= 2'h0;
    end else begin
      stage1_q <= raw;
      stage2_q <= stage1_q;
      clkPrev_q <= stage2_q[DSF_SYNC_W-1 -: 2];
    end
  end
  // Edges come from stage two only, never the first flop
  always_comb begin
    syncOut = stage2_q;
    syncOut.wrEdge = stage2_q[DSF_SYNC_W-1] & ~clkPrev_q[1];
    syncOut.rdEdge = stage2_q[DSF_SYNC_W-2] & ~clkPrev_q[0];
  end
endmodule
`default_nettype wire

// ### src/dsf_dual_fifo.sv
// Two independent 9-bit FIFOs with flags, tri-state data and IRQ
// Functional notes
// - Read one word per read edge, enables low
// - Empty flag low blocks reads entirely
// - Output enable low drives data outputs
// - Output enable high floats data outputs
// - Empty flag low when no words stored
// - Empty flag updated on read clock
// - Almost-empty at or below offset, default seven
// - Almost-empty flag updated on read clock
// - Almost-full within offset of full, default seven
// - Almost-full flag updated on write clock
// - Full flag low when full, blocks writes
// - Full flag updated on write clock
// - Write per write edge; mode adds enable two
// - Reset clears pointers and sets flag levels
// - Load pin level at reset selects mode
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/100ps
`default_nettype none
module dsf_dual_fifo #(
  parameter int DEPTH = dsf_pkg::DSF_DEPTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // FIFO pins, index 0 is the first FIFO
  input wire dsf_pkg::dsf_pins_t [1:0] fifoPins,
  input wire logic read_clock_first_fifo,
  input wire logic read_clock_second_fifo,
  input wire logic [1:0][dsf_pkg::DSF_DATA_W-1:0] dataIn,
  // FIFO outputs
  output dsf_pkg::dsf_flags_t [1:0] fifoFlags,
  output logic [1:0][dsf_pkg::DSF_DATA_W-1:0] dataOut,
  output logic [1:0] dataOutEn,
  // Register port
  input wire logic [dsf_pkg::DSF_REG_AW-1:0] regAddr,
  input wire logic [dsf_pkg::DSF_REG_DW-1:0] regWdata,
  input wire logic regWe,
  input wire logic regRe,
  output logic [dsf_pkg::DSF_REG_DW-1:0] regRdata,
  // Interrupt
  output logic irq
);
  import dsf_pkg::*;

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = PTR_W + 1;
  localparam int EV_W = DSF_NUM_FIFO * DSF_NUM_EV;
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] OFS_RST = CNT_W'(DSF_OFS_RST);

  // ------------------------------------------------------------
  // Shared state
  // ------------------------------------------------------------
  logic [1:0] readClock;
  dsf_sync_t [1:0] sy;
  logic [EV_W-1:0] evPulse;
  logic [EV_W-1:0] status_q;
  logic [EV_W-1:0] irqEn_q;
  logic irq_q;
  logic [DSF_REG_DW-1:0] regRdata_q;
  logic [DSF_REG_DW-1:0] rdMux;
  logic [1:0][CNT_W-1:0] cntView;
  logic [1:0][CNT_W-1:0] aeView;
  logic [1:0][CNT_W-1:0] afView;
  logic [1:0] modeView;
  dsf_flags_t [1:0] flags_q;
  logic [1:0][DSF_DATA_W-1:0] dataOut_q;
  logic [1:0] dataOutEn_q;

  assign readClock = {read_clock_second_fifo, read_clock_first_fifo};

  // ------------------------------------------------------------
  // Per-FIFO datapath
  // ------------------------------------------------------------
  // Each instance has its own pins, memory and flags; only clock, reset and register port are shared
  for (genvar i = 0; i < DSF_NUM_FIFO; i++) begin : g_fifo
    localparam logic [3:0] AE_ADDR = DSF_REG_AE_OFS0 + 4'(DSF_OFS_STRIDE * i);
    localparam logic [3:0] AF_ADDR = DSF_REG_AF_OFS0 + 4'(DSF_OFS_STRIDE * i);

    logic [DSF_DATA_W-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wrPtr_q;
    logic [PTR_W-1:0] rdPtr_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] aeOfs_q;
    logic [CNT_W-1:0] afOfs_q;
    logic modeDual_q;
    logic wrEnable;
    logic wrTry;
    logic rdTry;
    logic wrFire;
    logic rdFire;
    logic inReset;
    logic [1:0] primed_q;

    dsf_pin_sync u_sync (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .pins(fifoPins[i]),
      .readClock(readClock[i]),
      .dataIn(dataIn[i]),
      .syncOut(sy[i])
    );

    // Sync flops hold zeros after power-on reset; mask that false pin reset
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        primed_q <= 2'h0;
      end else begin
        primed_q <= {primed_q[0], 1'b1};
      end
    end

    assign inReset = ~sy[i].resetN & primed_q[1];

    // ----------------------------------------------------------
    // Request decode
    // ----------------------------------------------------------
    // In load mode the second pin is not a write enable
    assign wrEnable = ~sy[i].wen1N & (~modeDual_q | sy[i].wen2);
    assign wrTry = sy[i].wrEdge & wrEnable & ~inReset;
    assign rdTry = sy[i].rdEdge & ~sy[i].ren1N & ~sy[i].ren2N & ~inReset;
    assign wrFire = wrTry & flags_q[i].full_flag_n;
    assign rdFire = rdTry & flags_q[i].empty_flag_n;

    always_comb begin
      cnt_d = cnt_q;
      if (wrFire && !rdFire) begin
        cnt_d = cnt_q + CNT_W'(1);
      end else if (rdFire && !wrFire) begin
        cnt_d = cnt_q - CNT_W'(1);
      end
    end

    // ----------------------------------------------------------
    // Mode strap, caught while the reset pin is held low
    // ----------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        modeDual_q <= 1'b1;
      end else if (inReset) begin
        modeDual_q <= sy[i].wen2;
      end
    end

    // ----------------------------------------------------------
    // Storage
    // ----------------------------------------------------------
    always_ff @(posedge ref_clk) begin
      if (wrFire) begin
        mem[wrPtr_q] <= sy[i].data;
      end
    end

    // ----------------------------------------------------------
    // Pointers and fill level
    // ----------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        wrPtr_q <= '0;
        rdPtr_q <= '0;
        cnt_q <= '0;
      end else if (inReset) begin
        wrPtr_q <= '0;
        rdPtr_q <= '0;
        cnt_q <= '0;
      end else begin
        if (wrFire) begin
          wrPtr_q <= wrPtr_q + PTR_W'(1);
        end
        if (rdFire) begin
          rdPtr_q <= rdPtr_q + PTR_W'(1);
        end
        cnt_q <= cnt_d;
      end
    end

    // ----------------------------------------------------------
    // Read data and output drive
    // ----------------------------------------------------------
    // Word holds until the next accepted read
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        dataOut_q[i] <= '0;
      end else if (rdFire) begin
        dataOut_q[i] <= mem[rdPtr_q];
      end
    end

    // Follows the enable pin alone, not the read clock
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        dataOutEn_q[i] <= 1'b0;
      end else begin
        dataOutEn_q[i] <= ~sy[i].oeN;
      end
    end

    // ----------------------------------------------------------
    // Read-side flags, moved only on read clock edges
    // ----------------------------------------------------------
    // A write is seen by these flags at the next read edge
    // Compared against cnt_d so this edge's own access counts
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        flags_q[i].empty_flag_n <= 1'b0;
        flags_q[i].almost_empty_flag_n <= 1'b0;
      end else if (inReset) begin
        flags_q[i].empty_flag_n <= 1'b0;
        flags_q[i].almost_empty_flag_n <= 1'b0;
      end else if (sy[i].rdEdge) begin
        flags_q[i].empty_flag_n <= (cnt_d != '0);
        flags_q[i].almost_empty_flag_n <= (cnt_d > aeOfs_q);
      end
    end

    // ----------------------------------------------------------
    // Write-side flags, moved only on write clock edges
    // ----------------------------------------------------------
    // A read is seen by these flags at the next write edge
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        flags_q[i].full_flag_n <= 1'b1;
        flags_q[i].almost_full_flag_n <= 1'b1;
      end else if (inReset) begin
        flags_q[i].full_flag_n <= 1'b1;
        flags_q[i].almost_full_flag_n <= 1'b1;
      end else if (sy[i].wrEdge) begin
        flags_q[i].full_flag_n <= (cnt_d != FULL_CNT);
        flags_q[i].almost_full_flag_n <= ((FULL_CNT - cnt_d) > afOfs_q);
      end
    end

    // ----------------------------------------------------------
    // Offset registers
    // ----------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        aeOfs_q <= OFS_RST;
      end else if (inReset) begin
        aeOfs_q <= OFS_RST;
      end else if (regWe && regAddr == AE_ADDR) begin
        aeOfs_q <= regWdata[CNT_W-1:0];
      end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        afOfs_q <= OFS_RST;
      end else if (inReset) begin
        afOfs_q <= OFS_RST;
      end else if (regWe && regAddr == AF_ADDR) begin
        afOfs_q <= regWdata[CNT_W-1:0];
      end
    end

    // ----------------------------------------------------------
    // Events
    // ----------------------------------------------------------
    assign evPulse[DSF_NUM_EV*i + DSF_EV_EMPTY] =
      sy[i].rdEdge & ~inReset & flags_q[i].empty_flag_n & (cnt_d == '0);
    assign evPulse[DSF_NUM_EV*i + DSF_EV_FULL] =
      sy[i].wrEdge & ~inReset & flags_q[i].full_flag_n & (cnt_d == FULL_CNT);
    // Blocked attempts are flagged so software can spot misuse
    assign evPulse[DSF_NUM_EV*i + DSF_EV_RD_BLK] = rdTry & ~flags_q[i].empty_flag_n;
    assign evPulse[DSF_NUM_EV*i + DSF_EV_WR_BLK] = wrTry & ~flags_q[i].full_flag_n;

    assign cntView[i] = cnt_q;
    assign aeView[i] = aeOfs_q;
    assign afView[i] = afOfs_q;
    assign modeView[i] = modeDual_q;
  end

  // ------------------------------------------------------------
  // Interrupt status, enable and clear
  // ------------------------------------------------------------
  // A new event beats a clear landing in the same cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_q <= '0;
    end else if (regWe && regAddr == DSF_REG_IRQ_CLR) begin
      status_q <= evPulse | (status_q & ~regWdata[EV_W-1:0]);
    end else begin
      status_q <= evPulse | status_q;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irqEn_q <= DSF_IRQ_EN_RST;
    end else if (regWe && regAddr == DSF_REG_IRQ_EN) begin
      irqEn_q <= regWdata[EV_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & irqEn_q);
    end
  end

  // ------------------------------------------------------------
  // Register read
  // ------------------------------------------------------------
  always_comb begin
    rdMux = '0;
    case (regAddr)
      DSF_REG_STATUS: rdMux[EV_W-1:0] = status_q;
      DSF_REG_IRQ_EN: rdMux[EV_W-1:0] = irqEn_q;
      DSF_REG_AE_OFS0: rdMux[CNT_W-1:0] = aeView[0];
      DSF_REG_AF_OFS0: rdMux[CNT_W-1:0] = afView[0];
      DSF_REG_AE_OFS0 + 4'h2: rdMux[CNT_W-1:0] = aeView[1];
      DSF_REG_AF_OFS0 + 4'h2: rdMux[CNT_W-1:0] = afView[1];
      DSF_REG_LEVEL0: rdMux[CNT_W-1:0] = cntView[0];
      DSF_REG_LEVEL0 + 4'h1: rdMux[CNT_W-1:0] = cntView[1];
      DSF_REG_MODE: rdMux[1:0] = modeView;
      default: rdMux = '0;
    endcase
  end

  // Data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata_q <= '0;
    end else if (regRe) begin
      regRdata_q <= rdMux;
    end else begin
      regRdata_q <= '0;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign fifoFlags = flags_q;
  assign dataOut = dataOut_q;
  assign dataOutEn = dataOutEn_q;
  assign regRdata = regRdata_q;
  assign irq = irq_q;
endmodule
`default_nettype wire

// ### dv/dsf_dual_fifo_sva.sv
// Flag timing and output-enable checks for the first FIFO
`timescale 1ns/100ps
`default_nettype none
module dsf_dual_fifo_sva #(
  parameter int DEPTH = 256
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Pins
  input wire dsf_pkg::dsf_pins_t [1:0] fifoPins,
  input wire logic read_clock_first_fifo,
  // Outputs
  input wire dsf_pkg::dsf_flags_t [1:0] fifoFlags,
  input wire logic [1:0][dsf_pkg::DSF_DATA_W-1:0] dataOut,
  input wire logic [1:0] dataOutEn
);
  import dsf_pkg::*;
  logic [6:0] rdHist_q;
  logic [6:0] wrHist_q;
  dsf_flags_t f0;
  assign f0 = fifoFlags[0];
  // Pin clock history: a flag may move only shortly after its own clock
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdHist_q <= 7'h00;
    end else begin
      rdHist_q <= {rdHist_q[5:0], read_clock_first_fifo};
    end
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrHist_q <= 7'h00;
    end else begin
      wrHist_q <= {wrHist_q[5:0], fifoPins[0].write_clock};
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_rstFlags;
    $rose(arst_n) |-> f0 == 4'b0011;
  endproperty
  a_rstFlags: assert property (p_rstFlags) else $error("flags after reset");
  property p_rdBlock;
    !f0.empty_flag_n |=> $stable(dataOut[0]);
  endproperty
  a_rdBlock: assert property (p_rdBlock) else $error("read while empty");
  property p_oeOn;
    !fifoPins[0].output_enable_n [*6] |-> dataOutEn[0];
  endproperty
  a_oeOn: assert property (p_oeOn) else $error("outputs not driven");
  property p_oeOff;
    fifoPins[0].output_enable_n [*6] |-> !dataOutEn[0];
  endproperty
  a_oeOff: assert property (p_oeOff) else $error("outputs not floating");
  property p_emptySync;
    $changed(f0.empty_flag_n) |-> rdHist_q != 7'h00;
  endproperty
  a_emptySync: assert property (p_emptySync) else $error("empty off read clock");
  property p_aeSync;
    $changed(f0.almost_empty_flag_n) |-> rdHist_q != 7'h00;
  endproperty
  a_aeSync: assert property (p_aeSync) else $error("almost empty off read clock");
  property p_fullSync;
    $changed(f0.full_flag_n) |-> wrHist_q != 7'h00;
  endproperty
  a_fullSync: assert property (p_fullSync) else $error("full off write clock");
  property p_afSync;
    $changed(f0.almost_full_flag_n) |-> wrHist_q != 7'h00;
  endproperty
  a_afSync: assert property (p_afSync) else $error("almost full off write clock");
  property p_aeEmpty;
    !f0.empty_flag_n |-> !f0.almost_empty_flag_n;
  endproperty
  a_aeEmpty: assert property (p_aeEmpty) else $error("empty without almost empty");
  c_full: cover property (!f0.full_flag_n);
  c_blocked: cover property (!f0.empty_flag_n && rdHist_q[0]);
  c_oeOff: cover property (!dataOutEn[0]);
endmodule
bind dsf_dual_fifo dsf_dual_fifo_sva #(.DEPTH(DEPTH)) dsf_dual_fifo_sva_inst (
  .ref_clk(ref_clk), .arst_n(arst_n), .fifoPins(fifoPins),
  .read_clock_first_fifo(read_clock_first_fifo), .fifoFlags(fifoFlags),
  .dataOut(dataOut), .dataOutEn(dataOutEn));
`default_nettype wire

// ### dv/dsf_fifo_peer.sv
// Producer and consumer model driving the pins of both FIFOs
`timescale 1ns/100ps
`default_nettype none
module dsf_fifo_peer (
  // Clock
  input wire logic ref_clk,
  // Pins
  output dsf_pkg::dsf_pins_t [1:0] pins,
  output logic [1:0] rdClk,
  output logic [1:0][dsf_pkg::DSF_DATA_W-1:0] dataIn,
  // Read finished, word settled
  output logic [1:0] rdDone
);
  import dsf_pkg::*;
  initial begin
    pins = {2{7'h3d}};
    rdClk = 2'h0;
    dataIn = '0;
    rdDone = 2'h0;
  end
  // Three cycles a phase, above the two the pin sampler needs
  task automatic step;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic wrEdge(input int i, input logic [8:0] d, input logic en, input logic en2);
    @(posedge ref_clk);
    pins[i].write_enable_one_n <= ~en;
    pins[i].write_enable_two_or_offset_load <= en2;
    dataIn[i] <= d;
    step();
    pins[i].write_clock <= 1'b1;
    step();
    pins[i].write_clock <= 1'b0;
    pins[i].write_enable_one_n <= 1'b1;
    dataIn[i] <= ~d;
    step();
  endtask
  task automatic rdEdge(input int i, input logic en);
    @(posedge ref_clk);
    pins[i].read_enable_one_n <= ~en;
    pins[i].read_enable_two_n <= ~en;
    step();
    rdClk[i] <= 1'b1;
    step();
    rdClk[i] <= 1'b0;
    pins[i].read_enable_one_n <= 1'b1;
    pins[i].read_enable_two_n <= 1'b1;
    step();
    rdDone[i] <= 1'b1;
    @(posedge ref_clk);
    rdDone[i] <= 1'b0;
  endtask
  task automatic resetFifo(input int i, input logic dual);
    @(posedge ref_clk);
    pins[i].resetN <= 1'b0;
    pins[i].write_enable_two_or_offset_load <= dual;
    repeat (6) @(posedge ref_clk);
    pins[i].resetN <= 1'b1;
    step();
    step();
  endtask
  task automatic setOe(input int i, input logic v);
    @(posedge ref_clk);
    pins[i].output_enable_n <= v;
    repeat (6) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// ### dv/test_dual_sync_fifo_read_flags.sv
// Self-checking bench for the dual FIFO read path and flags
`timescale 1ns/100ps
`default_nettype none
module test_dual_sync_fifo_read_flags;
  import dsf_pkg::*;
  // ----
  // Hookup
  // ----
  localparam int DEPTH = 16;  // Small so full is reached quickly
  localparam logic [3:0] LVL1 = DSF_REG_LEVEL0 + 4'h1;
  typedef struct packed {logic [8:0] word; logic emptyN; logic aeN;} dsf_note_t;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  dsf_pins_t [1:0] pins;
  logic [1:0] rdClk, rdDone, dataOutEn;
  logic [1:0][DSF_DATA_W-1:0] dataIn, dataOut;
  dsf_flags_t [1:0] flags;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0000;
  logic [15:0] regRdata;
  logic regWe = 1'b0;
  logic regRe = 1'b0;
  logic irq;
  int numErrors = 0;
  int testsRun = 0;
  dsf_note_t notes[$];
  logic [8:0] model[$];
  logic [8:0] lastWord = 9'h000;
  dsf_dual_fifo #(.DEPTH(DEPTH)) dsf_dual_fifo_inst (
    .ref_clk(ref_clk), .arst_n(arst_n), .fifoPins(pins),
    .read_clock_first_fifo(rdClk[0]), .read_clock_second_fifo(rdClk[1]),
    .dataIn(dataIn), .fifoFlags(flags), .dataOut(dataOut), .dataOutEn(dataOutEn),
    .regAddr(regAddr), .regWdata(regWdata), .regWe(regWe), .regRe(regRe),
    .regRdata(regRdata), .irq(irq));
  dsf_fifo_peer dsf_fifo_peer_inst (.ref_clk(ref_clk), .pins(pins), .rdClk(rdClk),
    .dataIn(dataIn), .rdDone(rdDone));
  always #12.5 ref_clk = ~ref_clk;
  // ----
  // Tasks
  // ----
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    testsRun++;
    if (got !== exp) begin
      numErrors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic regWr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regWe <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWe <= 1'b0;
  endtask
  task automatic regRd(input logic [3:0] a, input logic [15:0] exp, input string what);
    @(posedge ref_clk);
    regRe <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRe <= 1'b0;
    #1 check(what, exp, regRdata);
  endtask
  // Refused reads keep the last word, so the note repeats it
  task automatic doRead(input int i, input logic en);
    int lvl;
    if (en && model.size() > 0) lastWord = model.pop_front();
    lvl = model.size();
    notes.push_back('{lastWord, lvl != 0, lvl > DSF_OFS_RST});
    dsf_fifo_peer_inst.rdEdge(i, en);
  endtask
  task automatic doWrite(input int i, input logic en, input logic en2, input logic acc);
    logic [8:0] d;
    d = 9'($urandom);
    if (acc) model.push_back(d);
    dsf_fifo_peer_inst.wrEdge(i, d, en, en2);
    #1 check("full", model.size() != DEPTH, flags[i].full_flag_n);
    check("almost full", DEPTH - model.size() > DSF_OFS_RST, flags[i].almost_full_flag_n);
  endtask
  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Result watcher: one note per finished read
  always @(negedge ref_clk) begin
    dsf_note_t n;
    int i;
    if (rdDone != 2'b00) begin
      i = rdDone[1] ? 1 : 0;
      n = notes.pop_front();
      check("word", n.word, dataOut[i]);
      check("empty", n.emptyN, flags[i].empty_flag_n);
      check("almost empty", n.aeN, flags[i].almost_empty_flag_n);
    end
  end
  initial begin
    #500000;
    numErrors++;
    conclude();
  end
  // ----
  // Tests
  // ----
  initial begin
    void'($urandom(18));
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    #1 check("reset flags 0", 4'b0011, flags[0]);
    check("reset flags 1", 4'b0011, flags[1]);
    for (int i = 0; i < 2; i++) dsf_fifo_peer_inst.resetFifo(i, 1'b1);
    doRead(0, 1'b1);
    regRd(DSF_REG_STATUS, 16'h0004, "status");
    check("irq masked", 1'b0, irq);
    regWr(DSF_REG_IRQ_EN, 16'h0004);
    repeat (3) @(posedge ref_clk);
    #1 check("irq raised", 1'b1, irq);
    regWr(DSF_REG_IRQ_CLR, 16'h0004);
    repeat (3) @(posedge ref_clk);
    #1 check("irq cleared", 1'b0, irq);
    regRd(4'hf, 16'h0000, "unmapped");
    regRd(DSF_REG_AE_OFS0, 16'h0007, "ae offset");
    regRd(DSF_REG_AF_OFS0, 16'h0007, "af offset");
    $display("test irq done");
    for (int i = 0; i < 2; i++) begin
      lastWord = 9'h000;
      for (int k = 0; k <= DEPTH; k++) doWrite(i, 1'b1, 1'b1, k < DEPTH);
      doRead(i, 1'b0);
      for (int k = 0; k <= DEPTH; k++) doRead(i, 1'b1);
      doWrite(i, 1'b0, 1'b1, 1'b0);
      check("other fifo", 1'b0, flags[1-i].empty_flag_n);
      $display("test fifo %0d done", i);
    end
    dsf_fifo_peer_inst.setOe(0, 1'b1);
    #1 check("outputs off", 1'b0, dataOutEn[0]);
    dsf_fifo_peer_inst.setOe(0, 1'b0);
    #1 check("outputs on", 1'b1, dataOutEn[0]);
    $display("test enable done");
    regRd(DSF_REG_MODE, 16'h0003, "mode dual");
    doWrite(1, 1'b1, 1'b0, 1'b0);
    regRd(LVL1, 16'h0000, "level refused");
    doWrite(1, 1'b1, 1'b1, 1'b1);
    regRd(LVL1, 16'h0001, "level dual");
    dsf_fifo_peer_inst.resetFifo(1, 1'b0);
    model.delete();
    #1 check("fifo reset flags", 4'b0011, flags[1]);
    regRd(DSF_REG_MODE, 16'h0001, "mode load");
    regRd(LVL1, 16'h0000, "level reset");
    doWrite(1, 1'b1, 1'b0, 1'b1);
    regRd(LVL1, 16'h0001, "level load");
    $display("test mode done");
    conclude();
  end
endmodule
`default_nettype wire
